// File: hw/crsf_regs.sv
// CPU register set: accumulator, index, stack, program counter and status.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - One 8-bit accumulator serves transfers, storage and flag results.
// RQ2 - Indexed mode adds X or Y to the given address as effective address.
// RQ3 - Index registers support increment, decrement, compare and transfer.
// RQ4 - An 8-bit stack pointer picks the location of every push and pop.
// RQ5 - Calls and accepted interrupts move the stack pointer by themselves.
// RQ6 - Sixteen-bit program counter is built from a high and a low byte.
// RQ7 - Reset loads the program counter with all ones.
// RQ8 - Status register holds the interrupt mask and six result flags.
// RQ9 - Status is pushed and pulled whole; single bits set or cleared.
// RQ10 - Instructions that do not affect flags leave the status unchanged.
// RQ11 - Negative flag takes bit 7 of each flag-updating result.
// RQ12 - Overflow sets when a signed sum or difference leaves -128..+127.
// RQ13 - Decimal flag selects binary or decimal arithmetic; software sets it.
// RQ14 - Interrupt disable blocks maskable requests; the non-maskable never.
// RQ15 - Zero flag is one for a zero result, zero otherwise.
// RQ16 - Carry is one on carry out of an add or no borrow of a subtract.
// RQ17 - Shifts and rotates through carry load it with the bit shifted out.
// RQ18 - Vectors: non-maskable, reset, maskable in the top six bytes.
// RQ19 - Push writes then decrements; pop increments then reads; page 0x1xx.
// RQ20 - Status layout is N, V, unused, B, D, I, Z, C from bit 7 down.
module crsf_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire crsf_pkg::crsf_cmd_s cmd,
    input wire logic cmd_valid,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_write,
    input wire logic sw_read,
    output logic [7:0] sw_rdata_q,
    output logic [7:0] acc_q,
    output logic [7:0] x_q,
    output logic [7:0] y_q,
    output logic [7:0] stack_pointer_q,
    output logic [15:0] pc_q,
    output logic [7:0] status_q,
    output logic [15:0] eff_addr_q,
    output logic [15:0] pop_addr_q,
    output crsf_pkg::crsf_mem_s mem_q,
    output logic [15:0] vec_addr_q,
    output logic int_accept_q,
    output logic busy_q
);
    import crsf_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_PUSH_LO, ST_PUSH_P} crsf_state_e;

    crsf_state_e state_q;
    logic in_int_q;
    logic [15:0] ret_q;
    logic [15:0] target_q;
    logic take;
    logic int_go;
    logic nmi_sel;
    logic [7:0] opv;
    logic [7:0] res;
    logic [7:0] status_d;
    logic [7:0] stack_pointer_d;
    logic wr_reg;
    logic [9:0] arith;

    function automatic logic [7:0] rsel(input crsf_reg_e s, input logic [7:0] a,
                                         input logic [7:0] x,
                                         input logic [7:0] y);
        case (s)
            R_X: rsel = x;
            R_Y: rsel = y;
            default: rsel = a;
        endcase
    endfunction

    // Result is {carry, overflow, value}.
    function automatic logic [9:0] add_fn(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic cin, input logic dec);
        logic [8:0] bin;
        logic [4:0] lo;
        logic [4:0] hi;
        logic ov;
        bin = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        ov = (a[7] == b[7]) && (bin[7] != a[7]);
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        if (lo > 5'h09) begin
            lo = lo + 5'h06;
        end
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) begin
            hi = hi + 5'h06;
        end
        if (dec) begin
            add_fn = {hi[4], ov, hi[3:0], lo[3:0]};
        end else begin
            add_fn = {bin[8], ov, bin[7:0]};
        end
    endfunction

    // Carry out means no borrow, in both modes.
    function automatic logic [9:0] sub_fn(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic cin, input logic dec);
        logic [8:0] bin;
        logic [4:0] lo;
        logic [4:0] hi;
        logic ov;
        bin = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        ov = (a[7] != b[7]) && (bin[7] != a[7]);
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
        if (lo[4]) begin
            lo = lo - 5'h06;
        end
        if (hi[4]) begin
            hi = hi - 5'h06;
        end
        if (dec) begin
            sub_fn = {bin[8], ov, hi[3:0], lo[3:0]};
        end else begin
            sub_fn = {bin[8], ov, bin[7:0]};
        end
    endfunction

    assign take = cmd_valid && (state_q == ST_IDLE);
    assign nmi_sel = nmi_req;
    // The mask gates only the maskable request.
    assign int_go = take && (cmd.op == OP_INT_POLL)
        && (nmi_req || (irq_req && !status_q[FLG_I])); // RQ14

    // Flag and result path; status_d defaults to the held value.
    always_comb begin
        opv = rsel(cmd.sel, acc_q, x_q, y_q);
        res = REG_RESET;
        wr_reg = 1'b0;
        status_d = status_q; // RQ10
        arith = add_fn(acc_q, cmd.data, status_q[FLG_C], status_q[FLG_D]);
        if (take) begin
            case (cmd.op)
                OP_ADC, OP_SBC: begin
                    if (cmd.op == OP_SBC) begin
                        arith = sub_fn(acc_q, cmd.data, status_q[FLG_C],
                                       status_q[FLG_D]); // RQ13
                    end
                    res = arith[7:0];
                    wr_reg = 1'b1;
                    status_d[FLG_C] = arith[9]; // RQ16
                    status_d[FLG_V] = arith[8]; // RQ12
                end
                OP_CMP: begin
                    arith = sub_fn(opv, cmd.data, 1'b1, 1'b0); // RQ3
                    res = arith[7:0];
                    status_d[FLG_C] = arith[9]; // RQ16
                end
                OP_INC: begin
                    res = opv + 8'h01; // RQ3
                    wr_reg = 1'b1;
                end
                OP_DEC: begin
                    res = opv - 8'h01; // RQ3
                    wr_reg = 1'b1;
                end
                OP_ASL, OP_ROL: begin
                    res = {opv[6:0],
                           (cmd.op == OP_ROL) ? status_q[FLG_C] : 1'b0};
                    status_d[FLG_C] = opv[7]; // RQ17
                    wr_reg = 1'b1;
                end
                OP_LSR, OP_ROR: begin
                    res = {(cmd.op == OP_ROR) ? status_q[FLG_C] : 1'b0,
                           opv[7:1]};
                    status_d[FLG_C] = opv[0]; // RQ17
                    wr_reg = 1'b1;
                end
                OP_LOAD, OP_POP: begin
                    res = cmd.data; // RQ1
                    wr_reg = 1'b1;
                end
                OP_TRANSFER: begin
                    res = rsel(cmd.src, acc_q, x_q, y_q); // RQ3
                    wr_reg = 1'b1;
                end
                OP_SETF: status_d[cmd.flag] = 1'b1; // RQ9
                OP_CLRF: status_d[cmd.flag] = 1'b0; // RQ9
                OP_PLP: status_d = cmd.data; // RQ9
                default: ;
            endcase
            case (cmd.op)
                OP_ADC, OP_SBC, OP_CMP, OP_INC, OP_DEC, OP_ASL, OP_ROL,
                OP_LSR, OP_ROR, OP_LOAD, OP_POP, OP_TRANSFER: begin
                    status_d[FLG_N] = res[7]; // RQ11
                    status_d[FLG_Z] = (res == 8'h00); // RQ15
                end
                default: ;
            endcase
        end
        if (state_q == ST_PUSH_P) begin
            status_d[FLG_I] = 1'b1; // RQ14
        end
    end

    // Stack moves by itself on calls and interrupt entry.
    always_comb begin
        stack_pointer_d = stack_pointer_q;
        if (take) begin
            case (cmd.op)
                OP_PUSH, OP_PHP, OP_CALL: begin
                    stack_pointer_d = stack_pointer_q - 8'h01; // RQ19
                end
                OP_POP, OP_PLP: begin
                    stack_pointer_d = stack_pointer_q + 8'h01; // RQ19
                end
                OP_TXS: stack_pointer_d = x_q;
                OP_INT_POLL: begin
                    if (int_go) begin
                        stack_pointer_d = stack_pointer_q - 8'h01; // RQ5
                    end
                end
                default: ;
            endcase
        end else if (state_q != ST_IDLE) begin
            stack_pointer_d = stack_pointer_q - 8'h01; // RQ5
        end
        if (sw_write && sw_addr == OFS_STACK && !take
            && state_q == ST_IDLE) begin
            stack_pointer_d = sw_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            stack_pointer_q <= SP_RESET;
            pop_addr_q <= {STACK_PAGE, SP_RESET + 8'h01};
        end else begin
            stack_pointer_q <= stack_pointer_d; // RQ4
            pop_addr_q <= {STACK_PAGE, stack_pointer_d + 8'h01}; // RQ19
        end
    end

    // Data registers; the sequencer wins over a software write.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_q <= REG_RESET;
            x_q <= REG_RESET;
            y_q <= REG_RESET;
        end else if (wr_reg) begin
            case (cmd.sel)
                R_X: x_q <= res; // RQ3
                R_Y: y_q <= res; // RQ3
                default: acc_q <= res; // RQ1
            endcase
        end else if (sw_write) begin
            case (sw_addr)
                OFS_ACC: acc_q <= sw_wdata;
                OFS_IDX_X: x_q <= sw_wdata;
                OFS_IDX_Y: y_q <= sw_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            status_q <= P_RESET;
        end else if (sw_write && sw_addr == OFS_STATUS && !take
                     && state_q == ST_IDLE) begin
            status_q <= sw_wdata;
        end else begin
            status_q <= status_d; // RQ8 RQ20
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            eff_addr_q <= PC_RESET;
        end else if (take && cmd.op == OP_INDEX) begin
            eff_addr_q <= cmd.addr + {8'h00,
                (cmd.sel == R_Y) ? y_q : x_q}; // RQ2
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pc_q <= PC_RESET; // RQ7
        end else if (take) begin
            case (cmd.op)
                OP_PC_INC: pc_q <= pc_q + 16'h0001;
                OP_JUMP: pc_q <= cmd.addr;
                OP_PCL_LOAD: pc_q[7:0] <= cmd.data; // RQ6
                OP_PCH_LOAD: pc_q[15:8] <= cmd.data; // RQ6
                default: ;
            endcase
        end else if (state_q == ST_PUSH_LO && !in_int_q) begin
            pc_q <= target_q;
        end else if (sw_write && state_q == ST_IDLE) begin
            if (sw_addr == OFS_PC_LO) begin
                pc_q[7:0] <= sw_wdata;
            end else if (sw_addr == OFS_PC_HI) begin
                pc_q[15:8] <= sw_wdata;
            end
        end
    end

    // Call and interrupt entry push high byte, then low byte; interrupt entry then pushes status.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            in_int_q <= 1'b0;
            ret_q <= PC_RESET;
            target_q <= PC_RESET;
            mem_q <= '0;
            vec_addr_q <= VEC_RESET; // RQ18
            int_accept_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            mem_q.we <= 1'b0;
            int_accept_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take && (cmd.op == OP_CALL || int_go)) begin
                        state_q <= ST_PUSH_LO; // RQ5
                        in_int_q <= int_go;
                        ret_q <= pc_q;
                        target_q <= cmd.addr;
                        mem_q <= '{1'b1, {STACK_PAGE, stack_pointer_q},
                                   pc_q[15:8]};
                        busy_q <= 1'b1;
                        if (int_go) begin
                            int_accept_q <= 1'b1;
                            vec_addr_q <= nmi_sel ? VEC_NMI : VEC_IRQ; // RQ18
                        end
                    end else if (take && (cmd.op == OP_PUSH
                                          || cmd.op == OP_PHP)) begin
                        mem_q <= '{1'b1, {STACK_PAGE, stack_pointer_q},
                                   (cmd.op == OP_PHP) ? status_q : opv}; // RQ9
                    end
                end
                ST_PUSH_LO: begin
                    mem_q <= '{1'b1, {STACK_PAGE, stack_pointer_q},
                               ret_q[7:0]};
                    state_q <= in_int_q ? ST_PUSH_P : ST_IDLE;
                    busy_q <= in_int_q;
                end
                ST_PUSH_P: begin
                    mem_q <= '{1'b1, {STACK_PAGE, stack_pointer_q},
                               status_q}; // RQ9
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sw_rdata_q <= REG_RESET;
        end else if (sw_read) begin
            case (sw_addr)
                OFS_ACC: sw_rdata_q <= acc_q;
                OFS_IDX_X: sw_rdata_q <= x_q;
                OFS_IDX_Y: sw_rdata_q <= y_q;
                OFS_STACK: sw_rdata_q <= stack_pointer_q;
                OFS_PC_LO: sw_rdata_q <= pc_q[7:0];
                OFS_PC_HI: sw_rdata_q <= pc_q[15:8];
                OFS_STATUS: sw_rdata_q <= status_q;
                default: sw_rdata_q <= REG_RESET;
            endcase
        end else begin
            sw_rdata_q <= REG_RESET;
        end
    end

endmodule // crsf_regs

`default_nettype wire

// File: hw/crsf_pkg.sv
// Shared constants, command encoding and carriers for the CPU register set.
package crsf_pkg;

    // Status register bit positions, bit 7 down to bit 0.
    localparam int FLG_N = 7;
    localparam int FLG_V = 6;
    localparam int FLG_U = 5;
    localparam int FLG_B = 4;
    localparam int FLG_D = 3;
    localparam int FLG_I = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;

    // Values after reset.
    localparam logic [15:0] PC_RESET = 16'hFFFF;
    localparam logic [7:0] P_RESET = 8'h34;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Stack page and exception vectors.
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [15:0] VEC_NMI = 16'hFFFA;
    localparam logic [15:0] VEC_RESET = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ = 16'hFFFE;

    // Software register port offsets.
    localparam logic [3:0] OFS_ACC = 4'h0;
    localparam logic [3:0] OFS_IDX_X = 4'h1;
    localparam logic [3:0] OFS_IDX_Y = 4'h2;
    localparam logic [3:0] OFS_STACK = 4'h3;
    localparam logic [3:0] OFS_PC_LO = 4'h4;
    localparam logic [3:0] OFS_PC_HI = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;

    typedef enum logic [4:0] {
        OP_NOP, OP_LOAD, OP_TRANSFER, OP_ADC, OP_SBC, OP_CMP, OP_INC,
        OP_DEC, OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_SETF, OP_CLRF,
        OP_PUSH, OP_POP, OP_PHP, OP_PLP, OP_INDEX, OP_CALL, OP_JUMP,
        OP_PC_INC, OP_PCL_LOAD, OP_PCH_LOAD, OP_INT_POLL, OP_TXS
    } crsf_op_e;

    typedef enum logic [1:0] {R_ACC, R_X, R_Y} crsf_reg_e;

    typedef struct packed {
        crsf_op_e op;
        crsf_reg_e sel;
        crsf_reg_e src;
        logic [2:0] flag;
        logic [7:0] data;
        logic [15:0] addr;
    } crsf_cmd_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } crsf_mem_s;

endpackage

// File: tb/crsf_mem_model.sv
// Stack memory model on the far side of the register set's memory bus.
`timescale 1ns/1ps
`default_nettype none
module crsf_mem_model (
    input wire logic clock,
    input wire crsf_pkg::crsf_mem_s mem,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);
    import crsf_pkg::*;
    logic [7:0] ram [256];
    // Cells start with a varying pattern so a stale or missing push shows.
    initial for (int i = 0; i < 256; i++) ram[i] = 8'hA5 ^ 8'(i);
    always @(posedge clock) begin
        if (mem.we && mem.addr[15:8] == STACK_PAGE) ram[mem.addr[7:0]] <= mem.wdata;
    end
    assign rd_data = ram[rd_addr];
endmodule // crsf_mem_model
`default_nettype wire

// File: tb/crsf_regs_chk.sv
// Concurrent checks on the ports of the CPU register set.
`timescale 1ns/1ps
`default_nettype none
module crsf_regs_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire crsf_pkg::crsf_cmd_s cmd,
    input wire logic cmd_valid,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic sw_write,
    input wire logic [7:0] acc_q,
    input wire logic [7:0] y_q,
    input wire logic [7:0] stack_pointer_q,
    input wire logic [15:0] pc_q,
    input wire logic [7:0] status_q,
    input wire logic [15:0] eff_addr_q,
    input wire crsf_pkg::crsf_mem_s mem_q,
    input wire logic [15:0] vec_addr_q,
    input wire logic int_accept_q,
    input wire logic busy_q
);
    import crsf_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic go;
    logic [8:0] sum;
    logic ovf;
    assign go = cmd_valid && !busy_q;
    assign sum = {1'b0, acc_q} + {1'b0, cmd.data} + {8'h00, status_q[FLG_C]};
    assign ovf = (acc_q[7] == cmd.data[7]) && (sum[7] != acc_q[7]);
    sequence call_go;
        go && cmd.op == OP_CALL;
    endsequence
    sequence int_go;
        go && cmd.op == OP_INT_POLL
            && (nmi_req || (irq_req && !status_q[FLG_I]));
    endsequence
    AST_PC_RESET: assert property (disable iff (1'b0)
        !rstn |=> pc_q == PC_RESET) else $error("pc not all ones in reset");
    AST_LOAD: assert property (go && cmd.op == OP_LOAD && cmd.sel == R_ACC
        |=> acc_q == $past(cmd.data) && status_q[FLG_N] == acc_q[7]
        && status_q[FLG_Z] == (acc_q == 8'h00)) else $error("load flags");
    AST_ADC: assert property (go && cmd.op == OP_ADC && !status_q[FLG_D]
        |=> status_q[FLG_C] == $past(sum[8]) && status_q[FLG_V] == $past(ovf)
        && acc_q == $past(sum[7:0])) else $error("binary add result");
    AST_KEEP: assert property (go && !sw_write
        && cmd.op inside {OP_NOP, OP_INDEX, OP_PUSH}
        |=> $stable(status_q)) else $error("status moved");
    AST_INDEX: assert property (go && cmd.op == OP_INDEX && cmd.sel == R_Y
        |=> eff_addr_q == $past(cmd.addr) + {8'h00, $past(y_q)})
        else $error("indexed address");
    AST_PUSH: assert property (go && cmd.op == OP_PUSH |=> mem_q.we
        && mem_q.addr == {STACK_PAGE, $past(stack_pointer_q)}
        && stack_pointer_q == $past(stack_pointer_q) - 8'h01)
        else $error("push address or pointer");
    AST_PHP: assert property (go && cmd.op == OP_PHP
        |=> mem_q.we && mem_q.wdata == $past(status_q)) else $error("php");
    AST_CALL: assert property (call_go |=> mem_q.we && busy_q
        && mem_q.wdata == $past(pc_q[15:8])
        ##1 mem_q.we && mem_q.wdata == $past(pc_q[7:0], 2)
        ##1 !mem_q.we && pc_q == $past(cmd.addr, 3)
        && stack_pointer_q == $past(stack_pointer_q, 3) - 8'h02)
        else $error("call sequence");
    AST_INT: assert property (int_go |=> int_accept_q
        ##0 mem_q.we [*3] ##1 status_q[FLG_I] && !busy_q
        && stack_pointer_q == $past(stack_pointer_q, 4) - 8'h03)
        else $error("interrupt entry");
    AST_VEC: assert property (int_go |=> vec_addr_q ==
        ($past(nmi_req) ? VEC_NMI : VEC_IRQ)) else $error("vector address");
    AST_MASK: assert property (go && cmd.op == OP_INT_POLL && !nmi_req
        && status_q[FLG_I] |=> !int_accept_q && !busy_q)
        else $error("masked request taken");
endmodule // crsf_regs_chk
bind crsf_regs crsf_regs_chk crsf_regs_chk_i (.clock(clock), .rstn(rstn),
    .cmd(cmd), .cmd_valid(cmd_valid), .irq_req(irq_req), .nmi_req(nmi_req),
    .sw_write(sw_write), .acc_q(acc_q), .y_q(y_q),
    .stack_pointer_q(stack_pointer_q), .pc_q(pc_q), .status_q(status_q),
    .eff_addr_q(eff_addr_q), .mem_q(mem_q), .vec_addr_q(vec_addr_q),
    .int_accept_q(int_accept_q), .busy_q(busy_q));
`default_nettype wire

// File: tb/crsf_regs_test.sv
// Self-checking bench for the CPU register set.
`timescale 1ns/1ps
`default_nettype none
module crsf_regs_test;
    import crsf_pkg::*;
    logic clock, rstn, cmd_valid, irq_req, nmi_req, sw_write, sw_read;
    crsf_cmd_s cmd;
    crsf_mem_s mem_q;
    logic [3:0] sw_addr;
    logic [7:0] sw_wdata, sw_rdata_q, acc_q, x_q, y_q, stack_pointer_q;
    logic [7:0] status_q, rd_addr, rd_data, got, a, b, p0;
    logic [15:0] pc_q, eff_addr_q, pop_addr_q, vec_addr_q;
    logic int_accept_q, busy_q, c, sub;
    logic [9:0] e;
    logic [31:0] seed = 32'd94;
    int miscompares = 0;
    int n_checks = 0;
    crsf_op_e sh [4] = '{OP_ASL, OP_LSR, OP_ROL, OP_ROR};
    crsf_regs crsf_regs_i (.clock(clock), .rstn(rstn), .cmd(cmd),
        .cmd_valid(cmd_valid), .irq_req(irq_req), .nmi_req(nmi_req),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
        .sw_read(sw_read), .sw_rdata_q(sw_rdata_q), .acc_q(acc_q), .x_q(x_q),
        .y_q(y_q), .stack_pointer_q(stack_pointer_q), .pc_q(pc_q),
        .status_q(status_q), .eff_addr_q(eff_addr_q), .pop_addr_q(pop_addr_q),
        .mem_q(mem_q), .vec_addr_q(vec_addr_q), .int_accept_q(int_accept_q),
        .busy_q(busy_q));
    crsf_mem_model crsf_mem_model_i (.clock(clock), .mem(mem_q),
        .rd_addr(rd_addr), .rd_data(rd_data));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Returns overflow, carry and the 8-bit sum.
    function automatic logic [9:0] add_exp(input logic [7:0] x,
        input logic [7:0] y, input logic ci);
        logic [8:0] s;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        return {(x[7] == y[7]) && (s[7] != x[7]), s};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Busy only lasts a few cycles, so a longer wait means a hang.
    task automatic run(input crsf_op_e o, input crsf_reg_e s,
        input logic [7:0] d, input logic [15:0] ad);
        @(posedge clock);
        cmd <= '{op: o, sel: s, src: R_X, flag: d[2:0], data: d, addr: ad};
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            if (busy_q === 1'b0) break;
            if (i == 7) begin
                miscompares++;
                complete_run();
            end
        end
        repeat (2) @(negedge clock);
    endtask
    task automatic sw(input logic wr, input logic [3:0] ad, input logic [7:0] d);
        @(posedge clock);
        sw_write <= wr;
        sw_read <= !wr;
        sw_addr <= ad;
        sw_wdata <= d;
        @(posedge clock);
        sw_write <= 1'b0;
        sw_read <= 1'b0;
        @(negedge clock);
        got = sw_rdata_q;
    endtask
    task automatic peek(input logic [7:0] ad);
        rd_addr = ad;
        #1;
        got = rd_data;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        {rstn, cmd_valid, irq_req, nmi_req, sw_write, sw_read} = 6'h00;
        cmd = '0;
        sw_addr = 4'h0;
        sw_wdata = 8'h00;
        rd_addr = 8'h00;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk(pc_q, PC_RESET);
        chk(vec_addr_q, VEC_RESET);
        chk(status_q, P_RESET);
        chk(stack_pointer_q, SP_RESET);
        sw(1'b0, OFS_PC_HI, 8'h00);
        chk(got, 8'hFF);
        sw(1'b0, 4'hA, 8'h00);
        chk(got, 8'h00);
        seed = xs(seed);
        sw(1'b1, OFS_IDX_X, seed[7:0]);
        sw(1'b0, OFS_IDX_X, 8'h00);
        chk(got, seed[7:0]);
        run(OP_CLRF, R_ACC, 8'(FLG_D), 16'h0000);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            {a, b, c, sub} = seed[17:0];
            if (i == 0) {a, b, c, sub} = {8'h7F, 8'h01, 2'b00};
            if (i == 1) {a, b, c, sub} = {8'h80, 8'h01, 2'b11};
            if (i == 2) {a, b, c, sub} = {8'hFF, 8'h01, 2'b00};
            run(OP_LOAD, R_ACC, a, 16'h0000);
            run(c ? OP_SETF : OP_CLRF, R_ACC, 8'(FLG_C), 16'h0000);
            run(sub ? OP_SBC : OP_ADC, R_ACC, b, 16'h0000);
            e = add_exp(a, sub ? ~b : b, c);
            chk(acc_q, e[7:0]);
            chk(status_q[FLG_C], e[8]);
            chk(status_q[FLG_V], e[9]);
            chk(status_q[FLG_N], e[7]);
            chk(status_q[FLG_Z], e[7:0] == 8'h00);
        end
        run(OP_SETF, R_ACC, 8'(FLG_D), 16'h0000);
        run(OP_LOAD, R_ACC, 8'h09, 16'h0000);
        run(OP_CLRF, R_ACC, 8'(FLG_C), 16'h0000);
        run(OP_ADC, R_ACC, 8'h01, 16'h0000);
        chk(acc_q, 8'h10);
        run(OP_CLRF, R_ACC, 8'(FLG_D), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            {a, c} = seed[8:0];
            run(OP_LOAD, R_X, a, 16'h0000);
            run(c ? OP_SETF : OP_CLRF, R_ACC, 8'(FLG_C), 16'h0000);
            run(sh[k], R_X, 8'h00, 16'h0000);
            e = k == 0 ? {1'b0, a, 1'b0} : k == 1 ? {1'b0, a[0], 1'b0, a[7:1]}
                : k == 2 ? {1'b0, a, c} : {1'b0, a[0], c, a[7:1]};
            chk(x_q, e[7:0]);
            chk(status_q[FLG_C], e[8]);
        end
        sw(1'b1, OFS_IDX_Y, 8'hF0);
        run(OP_INC, R_Y, 8'h00, 16'h0000);
        chk(y_q, 8'hF1);
        run(OP_INDEX, R_Y, 8'h00, 16'h1220);
        chk(eff_addr_q, 16'h1311);
        run(OP_LOAD, R_X, 8'h40, 16'h0000);
        run(OP_CMP, R_X, 8'h40, 16'h0000);
        chk(status_q[1:0], 2'b11);
        run(OP_DEC, R_X, 8'h00, 16'h0000);
        run(OP_TRANSFER, R_ACC, 8'h00, 16'h0000);
        chk(acc_q, 8'h3F);
        run(OP_LOAD, R_X, 8'hF0, 16'h0000);
        run(OP_TXS, R_ACC, 8'h00, 16'h0000);
        run(OP_LOAD, R_ACC, 8'h5A, 16'h0000);
        run(OP_PUSH, R_ACC, 8'h00, 16'h0000);
        peek(8'hF0);
        chk(got, 8'h5A);
        chk(pop_addr_q, 16'h01F0);
        run(OP_POP, R_Y, got, 16'h0000);
        chk(y_q, 8'h5A);
        p0 = status_q;
        run(OP_PHP, R_ACC, 8'h00, 16'h0000);
        run(OP_SETF, R_ACC, 8'(FLG_C), 16'h0000);
        peek(8'hF0);
        run(OP_PLP, R_ACC, got, 16'h0000);
        chk(status_q, p0);
        chk(stack_pointer_q, 8'hF0);
        run(OP_PCH_LOAD, R_ACC, 8'h12, 16'h0000);
        run(OP_PCL_LOAD, R_ACC, 8'h34, 16'h0000);
        chk(pc_q, 16'h1234);
        run(OP_CALL, R_ACC, 8'h00, 16'hABCD);
        chk(pc_q, 16'hABCD);
        chk(stack_pointer_q, 8'hEE);
        peek(8'hF0);
        chk(got, 8'h12);
        peek(8'hEF);
        chk(got, 8'h34);
        @(posedge clock);
        irq_req <= 1'b1;
        run(OP_SETF, R_ACC, 8'(FLG_I), 16'h0000);
        run(OP_INT_POLL, R_ACC, 8'h00, 16'h0000);
        chk(stack_pointer_q, 8'hEE);
        run(OP_CLRF, R_ACC, 8'(FLG_I), 16'h0000);
        run(OP_INT_POLL, R_ACC, 8'h00, 16'h0000);
        chk(vec_addr_q, VEC_IRQ);
        chk(stack_pointer_q, 8'hEB);
        chk(status_q[FLG_I], 1'b1);
        peek(8'hEE);
        chk(got, 8'hAB);
        @(posedge clock);
        irq_req <= 1'b0;
        nmi_req <= 1'b1;
        run(OP_INT_POLL, R_ACC, 8'h00, 16'h0000);
        chk(vec_addr_q, VEC_NMI);
        @(posedge clock);
        nmi_req <= 1'b0;
        run(OP_NOP, R_ACC, 8'h00, 16'h0000);
        complete_run();
    end
endmodule // crsf_regs_test
`default_nettype wire
